// [hw/cafp_pkg.sv]
// package: constants and types for the accumulator, flag and counter block
package cafp_pkg;

  // apb byte offsets; the flag register keeps its historic index 0x86
  // and sits at four times that index so every register is one word
  localparam logic [11:0] IDX_FLAGS = 12'h0086;
  localparam logic [11:0] OFF_FLAGS = {IDX_FLAGS[9:0], 2'h0};
  localparam logic [11:0] OFF_ACC = 12'h0000;
  localparam logic [11:0] OFF_PC = 12'h0004;
  localparam logic [11:0] OFF_OP = 12'h0008;
  localparam logic [11:0] OFF_STAT = 12'h000C;
  localparam logic [11:0] OFF_CLR = 12'h0010;
  localparam logic [11:0] OFF_IEN = 12'h0014;
  localparam logic [11:0] OFF_HIDE = 12'h0018;

  // flag field positions
  localparam int FB_ZERO = 0;
  localparam int FB_HALF = 1;
  localparam int FB_CARRY = 2;
  localparam int FB_MID = 4;
  localparam int FB_HIGH = 5;
  localparam int FB_CAUSE_LO = 6;
  localparam int FB_CAUSE_HI = 7;

  // reset cause encodings
  localparam logic [1:0] CAUSE_WDT = 2'h0;
  localparam logic [1:0] CAUSE_LVD = 2'h2;
  localparam logic [1:0] CAUSE_PIN = 2'h3;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // event bits in the sticky status register
  localparam int EV_JUMP = 0;
  localparam int EV_SKIP = 1;
  localparam int EV_ZERO = 2;
  localparam int EV_CARRY = 3;

  // operation codes written to the op register
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_INC = 5'h01, OP_ADD = 5'h02, OP_SUB = 5'h03,
    OP_AND = 5'h04, OP_OR = 5'h05, OP_XOR = 5'h06, OP_RLC = 5'h07,
    OP_RRC = 5'h08, OP_CMP = 5'h09, OP_LDA = 5'h0A, OP_JMP = 5'h0B,
    OP_CMPS = 5'h0C, OP_INCR_TO_ACC_SKIP = 5'h0D, OP_INCR_MEM_SKIP = 5'h0E, OP_DECR_TO_ACC_SKIP = 5'h0F,
    OP_DECR_MEM_SKIP = 5'h10, OP_BIT_CLEAR_TEST_SKIP = 5'h11, OP_BIT_SET_TEST_SKIP = 5'h12, OP_BANK_ZERO_CLEAR_TEST_SKIP = 5'h13,
    OP_BANK_ZERO_SET_TEST_SKIP = 5'h14, OP_PUSH = 5'h15, OP_POP = 5'h16, OP_ADDPC = 5'h17,
    OP_SUBPC = 5'h18
  } cafp_op_t;

  // one instruction as carried from the op register
  typedef struct packed {
    cafp_op_t op;
    logic [2:0] bitSel;
    logic [7:0] operand;
    logic [12:0] target;
  } cafp_instr_t;

  // alu answer
  typedef struct packed {
    logic [7:0] res;
    logic carry;
    logic half;
  } cafp_alu_t;

endpackage

// [hw/cafp_core.sv]
// accumulator, arithmetic and reset status flags, and program counter
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module cafp_core
  import cafp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset cause and supply detector inputs
  input wire logic [1:0] resetCause,
  input wire logic highDetectOption,
  input wire logic midDetectOption,
  input wire logic supplyAtOrBelowHigh,
  input wire logic midDetectorActive,
  // memory operand and interrupt entry
  input wire logic [7:0] memData,
  input wire logic intEntry,
  // outputs
  output logic [7:0] memWrData,
  output logic memWrEn,
  output logic [12:0] pcOut,
  output logic irq
);

  // op word layout on the bus: [28:24] operation code, [23:21] bit
  // select for the bit tests, [20:13] operand byte, [12:0] jump target.
  // the operand byte travels inside the op word, so memData is a spare
  // input kept for a later fetch from data memory and is not read here.
  // intEntry is deliberately left unread: interrupt entry saves nothing,
  // software keeps accumulator and flags with push and pop.
  // every op lands on the access edge of its bus write and is seen by
  // software one edge later; ops cannot overlap since each needs its
  // own bus transfer, so there is no hazard between back to back ops.
  // the flag register answers at four times its historic index so
  // that every register is one aligned word on the bus.

  // state
  logic [7:0] acc_ff; // accumulator, read and written at OFF_ACC
  logic [2:0] aflags_ff; // carry, half, zero
  logic [1:0] cause_ff; // caught at first clock after reset
  logic causeDone_ff; // set once cause is captured
  logic [7:0] accHide_ff; // hidden push buffer for accumulator
  logic [2:0] flagHide_ff; // hidden push buffer for flags
  logic [12:0] pc_ff; // program counter
  logic [3:0] stat_ff; // sticky events
  logic [3:0] ien_ff; // event enables
  logic [7:0] memWrData_ff;
  logic memWrEn_ff;
  logic [31:0] prdata_ff;

  // bus decode
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic opWr;
  cafp_instr_t ins;
  cafp_alu_t alu;
  logic [7:0] flagsView;
  logic skipTrue;
  logic [3:0] events;
  logic memOp; // op write whose result goes to data memory

  // slave always ready in the access phase: zero wait states
  // (every register is a flop, so no read ever needs a wait)
  assign pready = 1'b1;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign opWr = wrEn & (paddr == OFF_OP);
  // op word fields, cast straight from the write data
  assign ins = cafp_instr_t'(pwdata[28:0]);
  // memory-destination ops never touch the accumulator
  assign memOp = opWr & (ins.op inside {OP_INCR_MEM_SKIP, OP_DECR_MEM_SKIP});

  // decode of the known offsets; others give slverr
  // a part-word address is refused as well: each register is a word
  always_comb
  begin
    unique case (paddr)
      OFF_FLAGS, OFF_ACC, OFF_PC, OFF_OP, OFF_STAT, OFF_CLR, OFF_IEN,
      OFF_HIDE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  // one adder serves add, subtract and compare, so all three agree on
  // what a borrow is
  // add with carry in, reporting carry and nibble carry
  function automatic cafp_alu_t addc(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic cin);
    cafp_alu_t r;
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.res = s[7:0];
    r.carry = s[8];
    r.half = n[4];
    return r;
  endfunction

  // subtraction as add of complement: carry means no borrow
  function automatic cafp_alu_t subnb(input logic [7:0] a,
                                      input logic [7:0] b);
    return addc(a, ~b, 1'b1);
  endfunction

  // alu result for the current operation
  // rotates take the old carry in and put the shifted-out bit in carry
  always_comb
  begin
    alu = '{res: acc_ff, carry: aflags_ff[0], half: aflags_ff[1]};
    unique case (ins.op)
      OP_ADD: alu = addc(acc_ff, ins.operand, 1'b0);
      OP_SUB, OP_CMP, OP_CMPS: alu = subnb(acc_ff, ins.operand);
      OP_INC, OP_INCR_TO_ACC_SKIP, OP_INCR_MEM_SKIP: alu.res = ins.operand + 8'h01;
      OP_DECR_TO_ACC_SKIP, OP_DECR_MEM_SKIP: alu.res = ins.operand - 8'h01;
      OP_AND: alu.res = acc_ff & ins.operand;
      OP_OR: alu.res = acc_ff | ins.operand;
      OP_XOR: alu.res = acc_ff ^ ins.operand;
      OP_LDA: alu.res = ins.operand;
      OP_RLC: // rotate shifts out bit 7 into carry
      begin
        alu.res = {ins.operand[6:0], aflags_ff[0]};
        alu.carry = ins.operand[7];
      end
      OP_RRC:
      begin
        alu.res = {aflags_ff[0], ins.operand[7:1]};
        alu.carry = ins.operand[0];
      end
      default: alu.res = acc_ff; // nothing computed: keep the old view
    endcase
  end

  // skip condition of the nine one-address skip ops
  // bit tests pick the operand bit with bitSel; the bank-zero forms
  // act the same here because the op word carries the byte directly
  always_comb
  begin
    unique case (ins.op)
      OP_CMPS: skipTrue = (acc_ff == ins.operand);
      OP_INCR_TO_ACC_SKIP, OP_INCR_MEM_SKIP: skipTrue = (ins.operand == 8'hFF);
      OP_DECR_TO_ACC_SKIP, OP_DECR_MEM_SKIP: skipTrue = (ins.operand == 8'h00);
      OP_BIT_CLEAR_TEST_SKIP, OP_BANK_ZERO_CLEAR_TEST_SKIP: skipTrue = ~ins.operand[ins.bitSel];
      OP_BIT_SET_TEST_SKIP, OP_BANK_ZERO_SET_TEST_SKIP: skipTrue = ins.operand[ins.bitSel];
      default: skipTrue = 1'b0;
    endcase
  end

  // accumulator: written by ops, bus write, or pop; never by intEntry
  // an op and a direct bus write cannot meet: each is its own transfer
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      acc_ff <= ACC_RST;
    else if (opWr)
    begin
      unique case (ins.op)
        OP_ADD, OP_SUB, OP_INC, OP_AND, OP_OR, OP_XOR, OP_LDA, OP_RLC,
        OP_RRC, OP_INCR_TO_ACC_SKIP, OP_DECR_TO_ACC_SKIP: acc_ff <= alu.res;
        OP_POP: acc_ff <= accHide_ff;
        default: acc_ff <= acc_ff; // interrupt entry has no path
      endcase
    end
    else if (wrEn && paddr == OFF_ACC)
      acc_ff <= pwdata[7:0];
  end

  // memory-destination results leave on the data bus, acc untouched
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      memWrData_ff <= 8'h00;
      memWrEn_ff <= 1'b0;
    end
    else
    begin
      // strobe lasts one cycle; data holds until the next memory op
      memWrEn_ff <= memOp;
      if (memOp)
        memWrData_ff <= alu.res;
    end
  end

  // arithmetic flags packed as {zero, half carry, carry}
  // ops that do not define a flag leave it as it was
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      aflags_ff <= 3'h0;
    else if (opWr)
    begin
      unique case (ins.op)
        OP_ADD, OP_SUB: aflags_ff <= {alu.res == 8'h00, alu.half,
                                      alu.carry};
        OP_CMP, OP_CMPS: aflags_ff <= {alu.res == 8'h00, aflags_ff[1],
                                       alu.carry};
        OP_RLC, OP_RRC: aflags_ff <= {aflags_ff[2], aflags_ff[1],
                                      alu.carry};
        OP_INC, OP_AND, OP_OR, OP_XOR, OP_INCR_TO_ACC_SKIP, OP_DECR_TO_ACC_SKIP, OP_INCR_MEM_SKIP,
        OP_DECR_MEM_SKIP: aflags_ff <= {alu.res == 8'h00, aflags_ff[1:0]};
        OP_POP: aflags_ff <= flagHide_ff;
        default: aflags_ff <= aflags_ff;
      endcase
    end
    else if (wrEn && paddr == OFF_FLAGS)
      aflags_ff <= {pwdata[FB_ZERO], pwdata[FB_HALF], pwdata[FB_CARRY]};
  end

  // hidden push buffers, only reachable through push and pop
  // (the bus may read them for test, never write them)
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      accHide_ff <= ACC_RST;
      flagHide_ff <= 3'h0;
    end
    else if (opWr && ins.op == OP_PUSH)
    begin
      accHide_ff <= acc_ff;
      flagHide_ff <= aflags_ff;
    end
  end

  // reset cause caught by a clocked process after release
  // the cause inputs are only trusted once reset has gone, so the pin
  // cause shows until the first edge after release copies them
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cause_ff <= CAUSE_PIN;
      causeDone_ff <= 1'b0;
    end
    else if (!causeDone_ff)
    begin
      cause_ff <= resetCause;
      causeDone_ff <= 1'b1;
    end
    else if (wrEn && paddr == OFF_FLAGS)
      cause_ff <= pwdata[FB_CAUSE_HI:FB_CAUSE_LO];
  end

  // program counter
  // a true skip adds two so the next instruction is passed over; the
  // subtract form only touches the low byte because the high byte can
  // only count up
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pc_ff <= PC_RST;
    else if (opWr)
    begin
      unique case (ins.op)
        OP_JMP: pc_ff <= ins.target;
        OP_ADDPC: // low byte carry bumps high byte
          pc_ff <= pc_ff + {5'h00, acc_ff};
        OP_SUBPC: // borrow leaves high byte
          pc_ff <= {pc_ff[12:8], pc_ff[7:0] - acc_ff};
        default:
          pc_ff <= pc_ff + (skipTrue ? 13'h0002 : 13'h0001);
      endcase
    end
    else if (wrEn && paddr == OFF_PC)
      pc_ff <= pwdata[12:0];
  end

  // events and interrupt registers; set wins over clear
  // each event is seen in the sticky status one edge after its op
  assign events[EV_JUMP] = opWr & (ins.op == OP_JMP);
  assign events[EV_SKIP] = opWr & skipTrue;
  // zero event only for add, sub, cmp, cmps, inc, and, or and xor
  assign events[EV_ZERO] = opWr & (alu.res == 8'h00) &
    (ins.op inside {OP_ADD, OP_SUB, OP_CMP, OP_CMPS, OP_INC, OP_AND,
    OP_OR, OP_XOR});
  assign events[EV_CARRY] = opWr & (ins.op == OP_ADD) & alu.carry;

  // sticky status: an event landing with a clear survives the clear,
  // so software can never lose an event that it has not yet read
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      stat_ff <= IRQ_RST;
    else if (wrEn && paddr == OFF_CLR)
      stat_ff <= (stat_ff & ~pwdata[3:0]) | events;
    else
      stat_ff <= stat_ff | events;
  end

  // event enables; irq is the and of enables and sticky bits, so an
  // enable set on an already pending bit raises irq at once
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ien_ff <= IRQ_RST;
    else if (wrEn && paddr == OFF_IEN)
      ien_ff <= pwdata[3:0];
  end

  // flag register view; detector bits valid only with their option
  // bit three has no flag and always reads zero
  always_comb
  begin
    flagsView = 8'h00;
    flagsView[FB_CAUSE_HI:FB_CAUSE_LO] = cause_ff;
    flagsView[FB_HIGH] = highDetectOption & supplyAtOrBelowHigh;
    flagsView[FB_MID] = midDetectOption & midDetectorActive;
    flagsView[FB_CARRY] = aflags_ff[0];
    flagsView[FB_HALF] = aflags_ff[1];
    flagsView[FB_ZERO] = aflags_ff[2];
  end

  // read data registered at the end of the setup cycle so it stands
  // through the whole access phase; an unmapped word reads zero
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFF_FLAGS: prdata_ff <= {24'h00_0000, flagsView};
        OFF_ACC: prdata_ff <= {24'h00_0000, acc_ff};
        OFF_PC: prdata_ff <= {19'h0_0000, pc_ff};
        OFF_STAT: prdata_ff <= {28'h000_0000, stat_ff};
        OFF_IEN: prdata_ff <= {28'h000_0000, ien_ff};
        OFF_HIDE: prdata_ff <= {21'h00_0000, flagHide_ff, accHide_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // outputs straight from flops, except irq: a plain level formed as the or of stat_ff anded bitwise with ien_ff
  assign prdata = prdata_ff;
  assign memWrData = memWrData_ff;
  assign memWrEn = memWrEn_ff;
  assign pcOut = pc_ff;
  assign irq = |(stat_ff & ien_ff);

endmodule // cafp_core

// [sim/cafp_core_properties.sv]
// checker: properties on the core's apb and counter ports
`timescale 1ns/1ps
module cafp_core_properties
  import cafp_pkg::*;
(
  // clock, reset, apb
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // core outputs
  input wire logic memWrEn,
  input wire logic [12:0] pcOut,
  input wire logic irq
);
  // access phase decodes
  wire acc = psel && penable;
  wire opWr = acc && pwrite && paddr == OFF_OP;
  wire [4:0] opc = pwdata[28:24];
  wire pcWr = acc && pwrite && paddr == OFF_PC;
  wire ienWr = acc && pwrite && paddr == OFF_IEN;
  wire known = paddr inside {OFF_FLAGS, OFF_ACC, OFF_PC, OFF_OP,
    OFF_STAT, OFF_CLR, OFF_IEN, OFF_HIDE};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // an op write of one code
  sequence s_op(c);
    opWr && opc == c;
  endsequence
  AST_READY: assert property (acc |-> pready)
    else $error("ready low in access");
  AST_ERR: assert property (acc && !known |-> pslverr)
    else $error("unmapped not refused");
  AST_RST_PC: assert property ($rose(nrst) |-> pcOut == PC_RST)
    else $error("pc not zero");
  AST_JMP: assert property (
    s_op(OP_JMP) |=> pcOut == $past(pwdata[12:0]))
    else $error("jump target");
  AST_STEP: assert property (
    opWr && opc <= 5'h0A |=> pcOut == $past(pcOut) + 13'h0001)
    else $error("pc step");
  AST_SKIP: assert property (
    s_op(OP_CMPS) |=> 13'(pcOut - $past(pcOut)) inside {13'h1, 13'h2})
    else $error("skip step");
  // the counter only moves on an op or a direct write
  AST_HOLD: assert property (!$stable(pcOut) |-> $past(opWr || pcWr))
    else $error("pc moved alone");
  AST_IRQ: assert property ($rose(irq) |-> $past(opWr || ienWr))
    else $error("irq rose alone");
  AST_MEMWR: assert property (
    memWrEn |-> $past(opWr && opc inside {OP_INCR_MEM_SKIP, OP_DECR_MEM_SKIP}) ##1 !memWrEn)
    else $error("memory write pulse");
endmodule // cafp_core_properties

bind cafp_core cafp_core_properties u_props (.mclk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .memWrEn,
  .pcOut, .irq);

// [sim/cafp_core_test.sv]
// testbench: register and instruction scenarios for the core
`timescale 1ns/1ps
module cafp_core_test
  import cafp_pkg::*;
;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic highDetectOption, midDetectOption, supplyAtOrBelowHigh;
  logic midDetectorActive, intEntry, memWrEn, irq;
  logic [1:0] resetCause;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] memData, memWrData;
  logic [12:0] pcOut;
  int miscompares, total_checks;

  cafp_core u_dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .resetCause, .highDetectOption,
    .midDetectOption, .supplyAtOrBelowHigh, .midDetectorActive,
    .memData, .intEntry, .memWrData, .memWrEn, .pcOut, .irq);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // setup, access held until ready, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic op(input cafp_op_t o, input logic [7:0] v,
    input logic [12:0] t);
    apb(1'b1, OFF_OP, {3'h0, o, 3'h0, v, t});
  endtask

  // counter sampled mid cycle, well clear of its update edge
  task automatic pcis(input logic [12:0] e);
    @(negedge mclk);
    chk({19'h0, pcOut}, {19'h0, e});
    @(posedge mclk);
  endtask

  task automatic t_reset;
    pcis(PC_RST);
    rdchk(OFF_FLAGS, 32'h0000_00A0);
    midDetectorActive <= 1'b1;
    @(posedge mclk);
    rdchk(OFF_FLAGS, 32'h0000_00B0);
    supplyAtOrBelowHigh <= 1'b0;
    rdchk(OFF_FLAGS, 32'h0000_0090);
    {highDetectOption, midDetectOption} <= 2'h0;
    supplyAtOrBelowHigh <= 1'b1;
    rdchk(OFF_FLAGS, 32'h0000_0080);
    {highDetectOption, midDetectOption} <= 2'h3;
    midDetectorActive <= 1'b0;
    rdchk(OFF_PC, 32'h0000_0000);
    rdchk(12'h01C, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask

  task automatic t_add;
    apb(1'b1, OFF_ACC, 32'h0000_008F);
    op(OP_ADD, 8'h71, 13'h0000);
    pcis(13'h0001);
    rdchk(OFF_ACC, 32'h0000_0000);
    rdchk(OFF_FLAGS, 32'h0000_00A7);
    rdchk(OFF_STAT, 32'h0000_000C);
    op(OP_ADD, 8'h02, 13'h0000);
    rdchk(OFF_FLAGS, 32'h0000_00A0);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // jump interrupt enabled, raised by a jump, then cleared
  task automatic t_jmp;
    apb(1'b1, OFF_IEN, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    op(OP_JMP, 8'h00, 13'h1ABC);
    pcis(13'h1ABC);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, OFF_CLR, 32'h0000_000F);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_skip;
    apb(1'b1, OFF_ACC, 32'h0000_0012);
    op(OP_CMPS, 8'h12, 13'h0000);
    pcis(13'h1ABE);
    op(OP_CMPS, 8'h13, 13'h0000);
    pcis(13'h1ABF);
    apb(1'b1, OFF_PC, 32'h0000_00FF);
    op(OP_NOP, 8'h00, 13'h0000);
    pcis(13'h0100);
    op(OP_INCR_MEM_SKIP, 8'hFF, 13'h0000);
    pcis(13'h0102);
    op(OP_DECR_MEM_SKIP, 8'h05, 13'h0000);
    pcis(13'h0103);
    chk({24'h00_0000, memWrData}, 32'h0000_0004);
    op(OP_INCR_MEM_SKIP, 8'h41, 13'h0000);
    pcis(13'h0104);
    chk({24'h00_0000, memWrData}, 32'h0000_0042);
  endtask

  task automatic t_keep;
    apb(1'b1, OFF_FLAGS, 32'h0000_0087);
    intEntry <= 1'b1;
    @(posedge mclk);
    intEntry <= 1'b0;
    rdchk(OFF_ACC, 32'h0000_0012);
    rdchk(OFF_FLAGS, 32'h0000_00A7);
    op(OP_PUSH, 8'h00, 13'h0000);
    rdchk(OFF_HIDE, 32'h0000_0712);
    apb(1'b1, OFF_ACC, 32'h0000_0055);
    apb(1'b1, OFF_FLAGS, 32'h0000_0080);
    op(OP_POP, 8'h00, 13'h0000);
    rdchk(OFF_ACC, 32'h0000_0012);
    rdchk(OFF_FLAGS, 32'h0000_00A7);
  endtask

  initial
  begin
    {nrst, psel, penable, pwrite, intEntry} = 5'h0;
    {paddr, pwdata, memData} = '0;
    resetCause = 2'h2;
    {highDetectOption, midDetectOption} = 2'h3;
    supplyAtOrBelowHigh = 1'b1;
    midDetectorActive = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_add();
    t_jmp();
    t_skip();
    t_keep();
    print_verdict();
  end
endmodule // cafp_core_test
